// File: logic/pin_mux_pkg.sv
// constants for the shared pin function multiplexer
package pin_mux_pkg;
  // pin counts of the three ports
  localparam int P0_W     = 5;   // bit 4 is the input-only reset-shared bit
  localparam int P0_OUT_W = 4;   // drivable bits of port zero
  localparam int P4_W     = 5;
  localparam int P5_W     = 2;   // bit 0 is pin 5.3, bit 1 is pin 5.4
  localparam int RST_BIT  = 4;   // reset_shared_input_bit inside port zero
  localparam int OSC_OUT_BIT = 2;
  localparam int OSC_IN_BIT  = 3;
  localparam int IRQ_A_BIT   = 0;
  localparam int IRQ_B_BIT   = 1;

  // register byte offsets
  localparam logic [7:0] OFS_P0_DATA    = 8'h00;
  localparam logic [7:0] OFS_P0_DIR     = 8'h04;
  localparam logic [7:0] OFS_P0_PULL    = 8'h08;
  localparam logic [7:0] OFS_P4_DATA    = 8'h0C;
  localparam logic [7:0] OFS_P4_DIR     = 8'h10;
  localparam logic [7:0] OFS_P4_PULL    = 8'h14;
  localparam logic [7:0] OFS_P5_DATA    = 8'h18;
  localparam logic [7:0] OFS_P5_DIR     = 8'h1C;
  localparam logic [7:0] OFS_P5_PULL    = 8'h20;
  localparam logic [7:0] OFS_FUNC_CTRL  = 8'h24;
  localparam logic [7:0] OFS_EDGE_SEL   = 8'h28;
  localparam logic [7:0] OFS_CONV_EN    = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h34;

  // function control field positions
  localparam int FUNC_W        = 10;
  localparam int F_EXT_RST_EN  = 0;
  localparam int F_OSC_LO      = 1;   // two-bit oscillator mode at [2:1]
  localparam int F_TA_EVENT    = 3;
  localparam int F_TB_EVENT    = 4;
  localparam int F_BUZ_A_EN    = 5;
  localparam int F_PWM_A_EN    = 6;
  localparam int F_BUZ_B_EN    = 7;
  localparam int F_PWM_B_EN    = 8;
  localparam int F_VREF_EXT    = 9;

  // oscillator mode encodings
  localparam logic [1:0] OSC_INTERNAL = 2'h0;
  localparam logic [1:0] OSC_CRYSTAL  = 2'h1;
  localparam logic [1:0] OSC_RC       = 2'h2;
  localparam logic [1:0] OSC_EXT_SIG  = 2'h3;

  // edge_select_reg encodings
  localparam logic [1:0] EDGE_FALL_DEF = 2'h0;
  localparam logic [1:0] EDGE_RISE     = 2'h1;
  localparam logic [1:0] EDGE_FALL     = 2'h2;
  localparam logic [1:0] EDGE_BOTH     = 2'h3;

  // interrupt status bits
  localparam int IRQ_W        = 3;
  localparam int IRQ_EXT_A    = 0;
  localparam int IRQ_EXT_B    = 1;
  localparam int IRQ_WAKE     = 2;

  // values after reset
  localparam logic [FUNC_W-1:0] FUNC_RST = 10'h001;
  localparam logic [1:0]        EDGE_RST = 2'h2;
  localparam logic [IRQ_W-1:0]  MASK_RST = 3'h0;
endpackage

// File: logic/level_change_detect.sv
// rise, fall and change detection on a group of synchronous inputs
`timescale 1ns/100ps
module level_change_detect #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] sig_in,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall,
  output logic              any_change
);
  typedef struct packed {
    logic         armed;
    logic [W-1:0] prev;
  } det_t;

  det_t det_ff;
  det_t nxt_det;

  // first cycle after reset only loads history, so a pulled-up pin is no edge
  always_comb begin
    nxt_det       = det_ff;
    nxt_det.armed = 1'b1;
    nxt_det.prev  = sig_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_ff <= '0;
    end else begin
      det_ff <= nxt_det;
    end
  end

  assign rise       = det_ff.armed ? (sig_in & ~det_ff.prev) : '0;
  assign fall       = det_ff.armed ? (~sig_in & det_ff.prev) : '0;
  assign any_change = |(rise | fall);
endmodule

// File: logic/shared_pin_function_mux.sv
// pin function multiplexer with apb register file and pin event interrupts
// Functional notes
// - reset pin off: input-only Schmitt general bit
// - never a pull-up on reset-shared bit
// - reset pin active low, held high normally
// - crystal or rc oscillator takes port zero bit three
// - crystal only takes port zero bit two
// - first irq edge follows edge select
// - second irq on falling edge only
// - port zero bit zero clocks timer a
// - port zero bit one clocks timer b
// - pin 5.4 carries buzzer a or pwm a
// - pin 5.3 carries buzzer b or pwm b
// - port zero change wakes low-power device
// - selectable pull-ups on ports zero, four, five
// - port four shares converter channels and reference
`timescale 1ns/100ps
module shared_pin_function_mux
  import pin_mux_pkg::*;
(
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [7:0]                  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [pin_mux_pkg::P0_W-1:0] port_zero_in,
  output logic      [pin_mux_pkg::P0_W-1:0] port_zero_out,
  output logic      [pin_mux_pkg::P0_W-1:0] port_zero_oe,
  output logic      [pin_mux_pkg::P0_W-1:0] port_zero_pull_en,
  input  wire logic [pin_mux_pkg::P4_W-1:0] port_four_in,
  output logic      [pin_mux_pkg::P4_W-1:0] port_four_out,
  output logic      [pin_mux_pkg::P4_W-1:0] port_four_oe,
  output logic      [pin_mux_pkg::P4_W-1:0] port_four_pull_en,
  input  wire logic [pin_mux_pkg::P5_W-1:0] port_five_in,
  output logic      [pin_mux_pkg::P5_W-1:0] port_five_out,
  output logic      [pin_mux_pkg::P5_W-1:0] port_five_oe,
  output logic      [pin_mux_pkg::P5_W-1:0] port_five_pull_en,
  output logic                             ext_reset_n,
  output logic                             osc_in_pin,
  input  wire logic                        osc_drive,
  output logic                             osc_out_pin,
  output logic                             timer_a_event_clk,
  output logic                             timer_b_event_clk,
  input  wire logic                        timer_a_ovf,
  input  wire logic                        timer_b_ovf,
  input  wire logic                        pulse_width_out_a,
  input  wire logic                        pulse_width_out_b,
  output logic      [pin_mux_pkg::P4_W-1:0] conv_channel_sel,
  output logic                             conv_high_reference_in,
  input  wire logic                        low_power_mode,
  output logic                             wakeup_req,
  output logic                             ext_irq_a,
  output logic                             ext_irq_b,
  output logic                             irq
);
  import pin_mux_pkg::*;

  typedef struct packed {
    logic [P0_OUT_W-1:0] p0_data;
    logic [P0_OUT_W-1:0] p0_dir;
    logic [P0_OUT_W-1:0] p0_pull;
    logic [P4_W-1:0]     p4_data;
    logic [P4_W-1:0]     p4_dir;
    logic [P4_W-1:0]     p4_pull;
    logic [P5_W-1:0]     p5_data;
    logic [P5_W-1:0]     p5_dir;
    logic [P5_W-1:0]     p5_pull;
    logic [FUNC_W-1:0]   func;
    logic [1:0]          edge_sel;
    logic [P4_W-1:0]     conv_en;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_mask;
    logic                buz_a;
    logic                buz_b;
    logic [31:0]         rdata;
    logic                slverr;
    logic                rst_n;
    logic                ev_a;
    logic                ev_b;
    logic                wake;
    logic                irq_a;
    logic                irq_b;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  logic [P0_W-1:0] p0_rise;
  logic [P0_W-1:0] p0_fall;
  logic            p0_change;
  logic            access;
  logic            setup;
  logic            a_edge;
  logic            b_edge;
  logic            wake_evt;
  logic [1:0]      osc_mode;
  logic            osc_ext;
  logic            osc_xtal;

  // widen a register field to a bus word
  function automatic logic [31:0] zx(input logic [15:0] v);
    zx = {16'h0000, v};
  endfunction

  // address check shared by read and write paths
  function automatic logic mapped(input logic [7:0] a);
    unique case (a)
      OFS_P0_DATA, OFS_P0_DIR, OFS_P0_PULL,
      OFS_P4_DATA, OFS_P4_DIR, OFS_P4_PULL,
      OFS_P5_DATA, OFS_P5_DIR, OFS_P5_PULL,
      OFS_FUNC_CTRL, OFS_EDGE_SEL, OFS_CONV_EN,
      OFS_IRQ_STATUS, OFS_IRQ_MASK: mapped = 1'b1;
      default:                      mapped = 1'b0;
    endcase
  endfunction

  level_change_detect #(
    .W (P0_W)
  ) u_p0_detect (
    .pclk       (pclk),
    .presetn    (presetn),
    .sig_in     (port_zero_in),
    .rise       (p0_rise),
    .fall       (p0_fall),
    .any_change (p0_change)
  );

  assign setup    = psel && !penable;
  assign access   = psel && penable;
  assign osc_mode = state_ff.func[F_OSC_LO+1:F_OSC_LO];
  assign osc_xtal = (osc_mode == OSC_CRYSTAL);
  assign osc_ext  = osc_xtal || (osc_mode == OSC_RC);

  // trigger edges of the two external interrupt pins
  always_comb begin
    unique case (state_ff.edge_sel)
      EDGE_RISE: a_edge = p0_rise[IRQ_A_BIT];
      EDGE_BOTH: a_edge = p0_rise[IRQ_A_BIT] || p0_fall[IRQ_A_BIT];
      EDGE_FALL, EDGE_FALL_DEF: a_edge = p0_fall[IRQ_A_BIT];
    endcase
    b_edge   = p0_fall[IRQ_B_BIT];
    wake_evt = p0_change && low_power_mode;
  end

  // next state: bus writes, read capture, event flags and pin functions
  always_comb begin
    nxt_state = state_ff;
    // read data is latched in setup so it comes from a flop in the zero-wait access
    if (setup) begin
      nxt_state.slverr = !mapped(paddr);
      nxt_state.rdata  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          OFS_P0_DATA:    nxt_state.rdata = zx({11'h000, port_zero_in});
          OFS_P0_DIR:     nxt_state.rdata = zx({12'h000, state_ff.p0_dir});
          OFS_P0_PULL:    nxt_state.rdata = zx({12'h000, state_ff.p0_pull});
          OFS_P4_DATA:    nxt_state.rdata = zx({11'h000, port_four_in & ~state_ff.conv_en});
          OFS_P4_DIR:     nxt_state.rdata = zx({11'h000, state_ff.p4_dir});
          OFS_P4_PULL:    nxt_state.rdata = zx({11'h000, state_ff.p4_pull});
          OFS_P5_DATA:    nxt_state.rdata = zx({14'h0000, port_five_in});
          OFS_P5_DIR:     nxt_state.rdata = zx({14'h0000, state_ff.p5_dir});
          OFS_P5_PULL:    nxt_state.rdata = zx({14'h0000, state_ff.p5_pull});
          OFS_FUNC_CTRL:  nxt_state.rdata = zx({6'h00, state_ff.func});
          OFS_EDGE_SEL:   nxt_state.rdata = zx({14'h0000, state_ff.edge_sel});
          OFS_CONV_EN:    nxt_state.rdata = zx({11'h000, state_ff.conv_en});
          OFS_IRQ_STATUS: nxt_state.rdata = zx({13'h0000, state_ff.irq_status});
          OFS_IRQ_MASK:   nxt_state.rdata = zx({13'h0000, state_ff.irq_mask});
          default:        nxt_state.rdata = 32'h0000_0000;
        endcase
      end
    end
    // writes land at the access edge; unmapped writes are dropped
    if (access && pwrite) begin
      unique case (paddr)
        OFS_P0_DATA:    nxt_state.p0_data  = pwdata[P0_OUT_W-1:0];
        OFS_P0_DIR:     nxt_state.p0_dir   = pwdata[P0_OUT_W-1:0];
        OFS_P0_PULL:    nxt_state.p0_pull  = pwdata[P0_OUT_W-1:0];
        OFS_P4_DATA:    nxt_state.p4_data  = pwdata[P4_W-1:0];
        OFS_P4_DIR:     nxt_state.p4_dir   = pwdata[P4_W-1:0];
        OFS_P4_PULL:    nxt_state.p4_pull  = pwdata[P4_W-1:0];
        OFS_P5_DATA:    nxt_state.p5_data  = pwdata[P5_W-1:0];
        OFS_P5_DIR:     nxt_state.p5_dir   = pwdata[P5_W-1:0];
        OFS_P5_PULL:    nxt_state.p5_pull  = pwdata[P5_W-1:0];
        OFS_FUNC_CTRL:  nxt_state.func     = pwdata[FUNC_W-1:0];
        OFS_EDGE_SEL:   nxt_state.edge_sel = pwdata[1:0];
        OFS_CONV_EN:    nxt_state.conv_en  = pwdata[P4_W-1:0];
        OFS_IRQ_STATUS: nxt_state.irq_status = state_ff.irq_status & ~pwdata[IRQ_W-1:0];
        OFS_IRQ_MASK:   nxt_state.irq_mask = pwdata[IRQ_W-1:0];
        default:        nxt_state.slverr   = 1'b1;
      endcase
    end
    // hardware set comes after the clear so a coincident event is kept
    if (a_edge) begin
      nxt_state.irq_status[IRQ_EXT_A] = 1'b1;
    end
    if (b_edge) begin
      nxt_state.irq_status[IRQ_EXT_B] = 1'b1;
    end
    if (wake_evt) begin
      nxt_state.irq_status[IRQ_WAKE] = 1'b1;
    end
    nxt_state.irq_a = a_edge;
    nxt_state.irq_b = b_edge;
    nxt_state.wake  = wake_evt;
    // buzzer outputs are the timer overflows divided by two
    if (timer_a_ovf) begin
      nxt_state.buz_a = !state_ff.buz_a;
    end
    if (timer_b_ovf) begin
      nxt_state.buz_b = !state_ff.buz_b;
    end
    // external reset follows the low-active pin only while enabled
    nxt_state.rst_n = state_ff.func[F_EXT_RST_EN] ? port_zero_in[RST_BIT] : 1'b1;
    nxt_state.ev_a  = state_ff.func[F_TA_EVENT] && port_zero_in[IRQ_A_BIT];
    nxt_state.ev_b  = state_ff.func[F_TB_EVENT] && port_zero_in[IRQ_B_BIT];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff          <= '0;
      state_ff.func     <= FUNC_RST;
      state_ff.edge_sel <= EDGE_RST;
      state_ff.irq_mask <= MASK_RST;
      state_ff.rst_n    <= 1'b1;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // port zero: bit four never drives and never pulls, oscillator pins override
  always_comb begin
    port_zero_out     = {1'b0, state_ff.p0_data};
    port_zero_oe      = {1'b0, state_ff.p0_dir};
    port_zero_pull_en = {1'b0, state_ff.p0_pull & ~state_ff.p0_dir};
    if (osc_ext) begin
      port_zero_oe[OSC_IN_BIT]      = 1'b0;
      port_zero_pull_en[OSC_IN_BIT] = 1'b0;
    end
    if (osc_xtal) begin
      port_zero_out[OSC_OUT_BIT]     = osc_drive;
      port_zero_oe[OSC_OUT_BIT]      = 1'b1;
      port_zero_pull_en[OSC_OUT_BIT] = 1'b0;
    end
  end

  // oscillator path is left unregistered: a clock cannot be resampled by pclk
  assign osc_in_pin  = osc_ext ? port_zero_in[OSC_IN_BIT] : 1'b0;
  assign osc_out_pin = osc_xtal ? osc_drive : 1'b0;

  // port four: converter channels release the digital driver and pull-up
  assign port_four_out          = state_ff.p4_data;
  assign port_four_oe           = state_ff.p4_dir & ~state_ff.conv_en;
  assign port_four_pull_en      = state_ff.p4_pull & ~state_ff.p4_dir & ~state_ff.conv_en;
  assign conv_channel_sel       = state_ff.conv_en;
  assign conv_high_reference_in = state_ff.func[F_VREF_EXT] && !state_ff.p4_dir[0];

  // port five: pwm wins over buzzer, either wins over the data latch
  always_comb begin
    port_five_out = state_ff.p5_data;
    port_five_oe  = state_ff.p5_dir;
    if (state_ff.func[F_PWM_B_EN]) begin
      port_five_out[0] = pulse_width_out_b;
    end else if (state_ff.func[F_BUZ_B_EN]) begin
      port_five_out[0] = state_ff.buz_b;
    end
    if (state_ff.func[F_PWM_A_EN]) begin
      port_five_out[1] = pulse_width_out_a;
    end else if (state_ff.func[F_BUZ_A_EN]) begin
      port_five_out[1] = state_ff.buz_a;
    end
    port_five_oe[0]   = state_ff.p5_dir[0] | state_ff.func[F_PWM_B_EN] | state_ff.func[F_BUZ_B_EN];
    port_five_oe[1]   = state_ff.p5_dir[1] | state_ff.func[F_PWM_A_EN] | state_ff.func[F_BUZ_A_EN];
    port_five_pull_en = state_ff.p5_pull & ~port_five_oe;
  end

  // remaining outputs from flops; irq masked, pslverr gated by access, pready tied high
  assign ext_reset_n       = state_ff.rst_n;
  assign timer_a_event_clk = state_ff.ev_a;
  assign timer_b_event_clk = state_ff.ev_b;
  assign wakeup_req        = state_ff.wake;
  assign ext_irq_a         = state_ff.irq_a;
  assign ext_irq_b         = state_ff.irq_b;
  assign irq               = |(state_ff.irq_status & state_ff.irq_mask);
  assign prdata            = state_ff.rdata;
  assign pslverr           = state_ff.slverr && access;
  assign pready            = 1'b1;
endmodule

// File: testbench/pin_mux_sva.sv
// port-level assertions for the shared pin function multiplexer
`timescale 1ns/100ps
module pin_mux_sva
  import pin_mux_pkg::*;
(
  input wire logic                          pclk,
  input wire logic                          presetn,
  input wire logic [pin_mux_pkg::P0_W-1:0] port_zero_in,
  input wire logic [pin_mux_pkg::P0_W-1:0] port_zero_out,
  input wire logic [pin_mux_pkg::P0_W-1:0] port_zero_oe,
  input wire logic [pin_mux_pkg::P0_W-1:0] port_zero_pull_en,
  input wire logic                          ext_reset_n,
  input wire logic                          osc_in_pin,
  input wire logic                          osc_drive,
  input wire logic                          osc_out_pin,
  input wire logic                          timer_a_event_clk,
  input wire logic                          ext_irq_a,
  input wire logic                          ext_irq_b,
  input wire logic                          low_power_mode,
  input wire logic                          wakeup_req
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // reset-shared bit is never driven nor pulled
  a_rst_bit_quiet: assert property (port_zero_oe[RST_BIT] == 1'b0)
    else $error("reset-shared bit driven");
  a_rst_bit_nopull: assert property (port_zero_pull_en[RST_BIT] == 1'b0)
    else $error("reset-shared bit pulled up");
  // a reset request needs the pin low one cycle earlier
  a_reset_follow: assert property (!ext_reset_n |-> !$past(port_zero_in[RST_BIT]))
    else $error("reset request without low pin");
  a_osc_in_route: assert property (osc_in_pin |-> port_zero_in[OSC_IN_BIT])
    else $error("oscillator input not from its pin");
  a_osc_out_route: assert property (osc_out_pin |-> port_zero_oe[OSC_OUT_BIT] && port_zero_out[OSC_OUT_BIT])
    else $error("oscillator output not on its pin");
  // edge pulses lag the pin by one registered stage
  a_irq_a_cause: assert property (ext_irq_a |-> $past(port_zero_in[0]) != $past(port_zero_in[0], 2))
    else $error("first irq without pin edge");
  a_irq_b_fall: assert property (ext_irq_b |-> $past(port_zero_in[1], 2) && !$past(port_zero_in[1]))
    else $error("second irq without falling edge");
  a_irq_b_fires: assert property ($past(presetn, 2) && $past(presetn) && $past(port_zero_in[1], 2)
    && !$past(port_zero_in[1]) |-> ext_irq_b) else $error("falling edge missed");
  a_event_copy: assert property (timer_a_event_clk |-> $past(port_zero_in[0]))
    else $error("event clock not from pin");
  a_wake_cause: assert property (wakeup_req |-> $past(low_power_mode) && $past(port_zero_in) != $past(port_zero_in, 2))
    else $error("wakeup without change in low power");

  c_irq_b: cover property (ext_irq_b);
  c_wake: cover property (wakeup_req);
  c_event: cover property (timer_a_event_clk);
endmodule

bind shared_pin_function_mux pin_mux_sva u_sva (
  .pclk(pclk), .presetn(presetn), .port_zero_in(port_zero_in), .port_zero_out(port_zero_out),
  .port_zero_oe(port_zero_oe), .port_zero_pull_en(port_zero_pull_en), .ext_reset_n(ext_reset_n),
  .osc_in_pin(osc_in_pin), .osc_drive(osc_drive), .osc_out_pin(osc_out_pin),
  .timer_a_event_clk(timer_a_event_clk), .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b),
  .low_power_mode(low_power_mode), .wakeup_req(wakeup_req)
);

// File: testbench/pin_board_model.sv
// board side of the twelve shared pins: drivers, pull-ups and floating lines
`timescale 1ns/100ps
module pin_board_model (
  input  wire logic        pclk,
  input  wire logic [11:0] drv_en,
  input  wire logic [11:0] drv_val,
  input  wire logic [11:0] dut_oe,
  input  wire logic [11:0] dut_out,
  input  wire logic [11:0] dut_pull,
  output logic      [11:0] pin
);
  logic [11:0] last_ff;

  // remembered level, so a floating pin can wander away from it
  always_ff @(posedge pclk) begin
    last_ff <= pin;
  end

  // device drive first, then board, then pull-up; an open pin flips each cycle
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      pin[i] = dut_oe[i] ? dut_out[i] : drv_en[i] ? drv_val[i] : dut_pull[i] ? 1'b1 : ~last_ff[i];
    end
  end
endmodule

// File: testbench/shared_pin_function_mux_bench.sv
// self-checking bench for the shared pin function multiplexer
`timescale 1ns/100ps
module shared_pin_function_mux_bench;
  import pin_mux_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, osc_drive, low_power_mode;
  logic        ext_reset_n, osc_in_pin, osc_out_pin, ev_a, ev_b, vref, wakeup_req, irq_a, irq_b, irq, e, x;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q, v;
  logic [1:0]  ovf, pwm;
  logic [4:0]  conv_sel;
  logic [11:0] drv_en, drv_val, pin, d_oe, d_out, d_pull;
  int          bad_count, n_compared, cyc;

  shared_pin_function_mux u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_zero_in(pin[4:0]), .port_zero_out(d_out[4:0]), .port_zero_oe(d_oe[4:0]), .port_zero_pull_en(d_pull[4:0]),
    .port_four_in(pin[9:5]), .port_four_out(d_out[9:5]), .port_four_oe(d_oe[9:5]), .port_four_pull_en(d_pull[9:5]),
    .port_five_in(pin[11:10]), .port_five_out(d_out[11:10]), .port_five_oe(d_oe[11:10]),
    .port_five_pull_en(d_pull[11:10]), .ext_reset_n(ext_reset_n), .osc_in_pin(osc_in_pin), .osc_drive(osc_drive),
    .osc_out_pin(osc_out_pin), .timer_a_event_clk(ev_a), .timer_b_event_clk(ev_b), .timer_a_ovf(ovf[0]),
    .timer_b_ovf(ovf[1]), .pulse_width_out_a(pwm[0]), .pulse_width_out_b(pwm[1]), .conv_channel_sel(conv_sel),
    .conv_high_reference_in(vref), .low_power_mode(low_power_mode), .wakeup_req(wakeup_req),
    .ext_irq_a(irq_a), .ext_irq_b(irq_b), .irq(irq)
  );
  pin_board_model u_board (.pclk(pclk), .drv_en(drv_en), .drv_val(drv_val), .dut_oe(d_oe), .dut_out(d_out),
    .dut_pull(d_pull), .pin(pin));

  always #25 pclk = ~pclk;

  // run-length ceiling, far above the few hundred cycles needed
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end

  task automatic test_done();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // one bit above the bus word so the error response is compared with the read data
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one apb transfer; an idle edge follows so the next setup never overlaps the release
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk({e, q}, {1'b0, exp});
  endtask

  function automatic logic edge_hit(input logic [1:0] s, input logic rise);
    if (s == EDGE_RISE) return rise;
    if (s == EDGE_BOTH) return 1'b1;
    return ~rise;
  endfunction

  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    osc_drive = 0; low_power_mode = 0; ovf = 0; pwm = 0; drv_en = 12'hFFF;
    drv_val = 12'hFFF;
    bad_count = 0; n_compared = 0; cyc = 0;
    v = $urandom(32'h1AEA);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_FUNC_CTRL, 32'(FUNC_RST));
    rd(OFS_EDGE_SEL, 32'(EDGE_RST));
    rd(OFS_IRQ_MASK, 32'(MASK_RST));
    apb(1'b0, 8'h3C, 32'h0);
    chk({e, q}, 33'h1_0000_0000);
    // low reset pin requests a reset, then the bit becomes a plain input
    drv_val[4] <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(ext_reset_n, 1'b0);
    apb(1'b1, OFS_FUNC_CTRL, 32'h0);
    v = $urandom;
    drv_val[4:0] <= v[4:0];
    repeat (2) @(posedge pclk);
    chk(ext_reset_n, 1'b1);
    rd(OFS_P0_DATA, {27'h0, v[4:0]});
    apb(1'b1, OFS_P0_PULL, 32'h1F);
    chk(d_pull[4:0], 5'h0F);
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, OFS_FUNC_CTRL, 32'(m * 2));
      v = $urandom;
      drv_val[3] <= v[0];
      osc_drive <= v[1];
      @(posedge pclk);
      #1;
      chk(osc_in_pin, (m == 1 || m == 2) ? v[0] : 1'b0);
      chk({d_oe[2], osc_out_pin}, (m == 1) ? {1'b1, v[1]} : 2'b00);
      @(posedge pclk);
    end
    apb(1'b1, OFS_FUNC_CTRL, 32'h0);
    apb(1'b1, OFS_IRQ_MASK, 32'h3);
    // every edge select against both directions on both irq pins
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, OFS_EDGE_SEL, 32'(s));
      for (int r = 0; r < 2; r++) begin
        drv_val[1:0] <= r[0] ? 2'b00 : 2'b11;
        repeat (2) @(posedge pclk);
        apb(1'b1, OFS_IRQ_STATUS, 32'h7);
        drv_val[1:0] <= {2{r[0]}};
        @(posedge pclk);
        #1;
        x = edge_hit(2'(s), r[0]);
        chk({irq_b, irq_a, irq}, {~r[0], x, x | ~r[0]});
        @(posedge pclk);
        rd(OFS_IRQ_STATUS, {30'h0, ~r[0], x});
      end
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, OFS_FUNC_CTRL, 32'h18);
    repeat (8) begin
      v = $urandom;
      drv_val[1:0] <= v[1:0];
      @(posedge pclk);
      #1;
      chk({ev_b, ev_a}, v[1:0]);
      @(posedge pclk);
    end
    // port five latch low and released: only the timer function may drive it
    apb(1'b1, OFS_P5_DATA, 32'h0);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFS_FUNC_CTRL, 32'h20 << (2 * k));
      for (int t = 1; t <= 3; t++) begin
        ovf[k] <= 1'b1;
        @(posedge pclk);
        ovf[k] <= 1'b0;
        repeat ($urandom_range(1, 4)) @(posedge pclk);
        #1;
        chk({d_oe[11 - k], d_out[11 - k]}, {1'b1, t[0]});
        @(posedge pclk);
      end
      apb(1'b1, OFS_FUNC_CTRL, 32'h60 << (2 * k));
      repeat (4) begin
        v = $urandom;
        pwm[k] <= v[0];
        @(posedge pclk);
        #1;
        chk({d_oe[11 - k], d_out[11 - k]}, {1'b1, v[0]});
        @(posedge pclk);
      end
    end
    apb(1'b1, OFS_FUNC_CTRL, 32'h0);
    apb(1'b1, OFS_IRQ_STATUS, 32'h7);
    apb(1'b1, OFS_IRQ_MASK, 32'h4);
    for (int w = 0; w < 2; w++) begin
      low_power_mode <= w[0];
      v = $urandom_range(0, 3);
      drv_val[v[1:0]] <= ~drv_val[v[1:0]];
      @(posedge pclk);
      #1;
      chk({wakeup_req, irq}, {2{w[0]}});
      @(posedge pclk);
      #1;
      chk(wakeup_req, 1'b0);
      @(posedge pclk);
    end
    // plain port drive: outputs follow the latches, pulls drop while driving
    apb(1'b1, OFS_P0_DIR, 32'hF);
    apb(1'b1, OFS_P0_DATA, 32'hA);
    apb(1'b1, OFS_P5_PULL, 32'h3);
    chk({d_oe[4:0], d_out[4:0], d_pull[4:0], d_pull[11:10]}, {5'h0F, 5'h0A, 5'h00, 2'h3});
    rd(OFS_P0_DIR, 32'h0F);
    rd(OFS_P5_DATA, 32'h3);
    // released port four: pulled bits read high, analog bits masked
    apb(1'b1, OFS_P4_PULL, 32'h1F);
    apb(1'b1, OFS_CONV_EN, 32'h15);
    drv_en[9:5] <= 5'h00;
    apb(1'b1, OFS_FUNC_CTRL, 32'h200);
    chk({vref, conv_sel, d_pull[9:5]}, {1'b1, 5'h15, 5'h0A});
    rd(OFS_P4_DATA, 32'h0A);
    // driving port four: analog bits stay released, reference needs bit zero as input
    apb(1'b1, OFS_P4_DATA, 32'h1F);
    apb(1'b1, OFS_P4_DIR, 32'h1F);
    chk({vref, d_oe[9:5], d_out[9:5], d_pull[9:5]}, {1'b0, 5'h0A, 5'h1F, 5'h00});
    test_done();
  end
endmodule
